//--- rtl/dcu_pkg.sv
// Package of constants and types for the dual capture unit interface
package dcu_pkg;
  // ----------------------------------------------------------------------
  // Register offsets (word index)
  // ----------------------------------------------------------------------
  localparam logic [4:0] DCU_OFF_SELECT    = 5'h00; // Interface select
  localparam logic [4:0] DCU_OFF_FAULT     = 5'h01; // Parameter fault flags
  localparam logic [4:0] DCU_OFF_IRQ_STAT  = 5'h02; // Sticky event status
  localparam logic [4:0] DCU_OFF_IRQ_MASK  = 5'h03; // Event mask
  localparam logic [4:0] DCU_OFF_PROBE_FN  = 5'h04; // Touch-probe function
  localparam logic [4:0] DCU_OFF_PROBE_ST  = 5'h05; // Touch-probe status
  localparam logic [4:0] DCU_OFF_PROBE_VAL = 5'h06; // Probe values base (4)
  localparam logic [4:0] DCU_OFF_VA_BASE   = 5'h10; // Vendor unit A block
  localparam logic [4:0] DCU_OFF_VB_BASE   = 5'h18; // Vendor unit B block
  // Offsets within a vendor unit block
  localparam logic [2:0] DCU_VU_CONFIG = 3'h0; // Trigger/edge/filter config
  localparam logic [2:0] DCU_VU_CMD    = 3'h1; // Unit command
  localparam logic [2:0] DCU_VU_STATE  = 3'h2; // Unit state
  localparam logic [2:0] DCU_VU_VAL0   = 3'h3; // Captured value 0..2
  localparam logic [2:0] DCU_VU_VAL2   = 3'h5; // Last captured value
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int DCU_CFG_TRIG_LSB = 0;  // Trigger input index, 3 bits
  localparam int DCU_CFG_SW_BIT   = 3;  // Software trigger source select
  localparam int DCU_CFG_BOTH_BIT = 4;  // Capture on both edges
  localparam int DCU_CFG_FALL_BIT = 5;  // Falling edge (else rising)
  localparam int DCU_CFG_REP_BIT  = 6;  // Repetitive mode
  localparam int DCU_CFG_FILT_BIT = 7;  // Spatial filter enable
  localparam int DCU_CMD_EN_BIT   = 0;  // Arm/enable
  localparam int DCU_CMD_SWT_BIT  = 1;  // Software trigger level
  localparam int DCU_FLT_IFACE    = 0;  // Wrong-interface warning
  localparam int DCU_FLT_SETUP    = 1;  // Setting refused warning
  localparam int DCU_PB_EN_A      = 0;  // Probe A enable / done bit
  localparam int DCU_PB_EN_B      = 8;  // Probe B enable / done bit
  localparam int DCU_PB_REP_A     = 1;  // Probe A repetitive
  localparam int DCU_PB_SRC_A     = 2;  // Probe A use software trigger
  localparam int DCU_PB_FALL_A    = 4;  // Probe A falling edge
  localparam int DCU_PB_BOTH_A    = 5;  // Probe A both edges
  localparam int DCU_PB_B_SHIFT   = 8;  // Unit B field offset
  // ----------------------------------------------------------------------
  // Reset and default values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  DCU_RST_CFG    = 8'h00;
  localparam logic [15:0] DCU_RST_PROBE  = 16'h0000;
  localparam logic [1:0]  DCU_RST_FAULT  = 2'h0;
  localparam logic [31:0] DCU_UNMAPPED   = 32'h0000_0000;
  // ----------------------------------------------------------------------
  // Unit state encoding and machine
  // ----------------------------------------------------------------------
  localparam logic [1:0] DCU_ST_IDLE  = 2'h0; // Disabled
  localparam logic [1:0] DCU_ST_ARMED = 2'h1; // Enabled, waiting
  localparam logic [1:0] DCU_ST_DONE  = 2'h2; // Capture completed
  typedef enum logic [2:0] {
    DCU_S_IDLE  = 3'b001,
    DCU_S_ARMED = 3'b010,
    DCU_S_DONE  = 3'b100
  } dcu_state_t;
endpackage : dcu_pkg

//--- rtl/dcu_top.sv
// Dual capture unit with vendor and touch-probe parameter interfaces
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dcu_top (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [4:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             abort_o,
  // Trigger inputs and captured quantities
  input  wire logic [7:0]  din_i,
  input  wire logic [31:0] qty_a0_i,
  input  wire logic [31:0] qty_a1_i,
  input  wire logic [31:0] qty_a2_i,
  input  wire logic [31:0] qty_b0_i,
  input  wire logic [31:0] qty_b1_i,
  input  wire logic [31:0] qty_b2_i,
  // Spatial filter window on first quantity
  input  wire logic [31:0] filt_span_i,
  // Nonvolatile store contents offered at an interface change
  input  wire logic        nv_ok_i,
  input  wire logic [15:0] nv_cfg_i,
  input  wire logic [15:0] nv_probe_i,
  // Interrupt
  output logic             irq_o
);
  import dcu_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic        sel_reg, sel_next;             // Interface select
  logic [1:0]  flt_reg, flt_next;             // Parameter fault flags
  logic [3:0]  ist_reg, ist_next;             // Sticky events
  logic [3:0]  imk_reg, imk_next;             // Event mask
  logic [7:0]  cfg_reg [2], cfg_next [2];     // Unit configuration
  logic [1:0]  cmd_reg, cmd_next;             // Enable bits per unit
  logic [1:0]  swt_reg, swt_next;             // Software trigger levels
  logic [1:0]  blk_reg, blk_next;             // Enable blocked after refusal
  dcu_state_t  st_reg [2], st_next [2];       // Unit machines
  logic [31:0] val_reg [6], val_next [6];     // Latched values
  logic [31:0] ref_reg [2], ref_next [2];     // Filter start position
  logic [1:0]  trg_reg, trg_next;             // Previous trigger level
  logic [1:0]  pend_reg, pend_next;           // Edge seen, awaiting filter
  logic [31:0] rdata_next;                    // Read data
  logic        abort_next;                    // Write abort
  logic        irq_next;                      // Interrupt level

  logic [31:0] qty [6];                       // Live quantities
  assign qty[0] = qty_a0_i;
  assign qty[1] = qty_a1_i;
  assign qty[2] = qty_a2_i;
  assign qty[3] = qty_b0_i;
  assign qty[4] = qty_b1_i;
  assign qty[5] = qty_b2_i;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Two-bit state code of a unit
  function automatic logic [1:0] dcu_code(input dcu_state_t s);
    case (s)
      DCU_S_ARMED: dcu_code = DCU_ST_ARMED;
      DCU_S_DONE:  dcu_code = DCU_ST_DONE;
      default:     dcu_code = DCU_ST_IDLE;
    endcase
  endfunction : dcu_code

  // Touch-probe field of one unit from its config and enable
  function automatic logic [7:0] dcu_pfn(input logic [7:0] c, input logic e);
    dcu_pfn = 8'h00;
    dcu_pfn[DCU_PB_EN_A]   = e;
    dcu_pfn[DCU_PB_REP_A]  = c[DCU_CFG_REP_BIT];
    dcu_pfn[DCU_PB_SRC_A]  = c[DCU_CFG_SW_BIT];
    dcu_pfn[DCU_PB_FALL_A] = c[DCU_CFG_FALL_BIT];
    dcu_pfn[DCU_PB_BOTH_A] = c[DCU_CFG_BOTH_BIT];
  endfunction : dcu_pfn

  // Vendor config from one probe function byte, input index kept
  function automatic logic [7:0] dcu_p2c(input logic [7:0] p,
                                         input logic [7:0] c);
    dcu_p2c = 8'h00;
    dcu_p2c[DCU_CFG_TRIG_LSB +: 3] = c[DCU_CFG_TRIG_LSB +: 3];
    dcu_p2c[DCU_CFG_REP_BIT]  = p[DCU_PB_REP_A];
    dcu_p2c[DCU_CFG_SW_BIT]   = p[DCU_PB_SRC_A];
    dcu_p2c[DCU_CFG_FALL_BIT] = p[DCU_PB_FALL_A];
    dcu_p2c[DCU_CFG_BOTH_BIT] = p[DCU_PB_BOTH_A];
  endfunction : dcu_p2c

  // Absolute difference of two positions
  function automatic logic [31:0] dcu_dist(input logic [31:0] a,
                                           input logic [31:0] b);
    dcu_dist = (a >= b) ? (a - b) : (b - a);
  endfunction : dcu_dist

  // Views used only by the touch-probe interface
  logic [15:0] pfn, pst;
  assign pfn = {dcu_pfn(cfg_reg[1], cmd_reg[1]),
                dcu_pfn(cfg_reg[0], cmd_reg[0])};
  always_comb begin
    // Probe status: done bit per unit
    pst = 16'h0000;
    pst[DCU_PB_EN_A] = (st_reg[0] == DCU_S_DONE);
    pst[DCU_PB_EN_B] = (st_reg[1] == DCU_S_DONE);
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic       busy;     // Interface change not allowed
    logic [2:0] voff;     // Offset inside vendor block
    logic       vhit;     // Vendor address hit
    logic       vu;       // Vendor unit index
    logic       phit;     // Probe address hit
    logic       trig;     // Selected trigger level
    logic       edge_ok;  // Programmed edge seen
    logic [7:0] nc;       // Candidate config
    busy = 1'b0; voff = 3'h0; vhit = 1'b0; vu = 1'b0; phit = 1'b0;
    trig = 1'b0; edge_ok = 1'b0; nc = 8'h00;
    sel_next = sel_reg; flt_next = flt_reg; imk_next = imk_reg;
    cmd_next = cmd_reg; swt_next = swt_reg; blk_next = blk_reg;
    pend_next = pend_reg; rdata_next = DCU_UNMAPPED; abort_next = 1'b0;
    ist_next = ist_reg;
    trg_next = trg_reg;
    for (int u = 0; u < 2; u++) begin
      cfg_next[u] = cfg_reg[u]; st_next[u] = st_reg[u];
      ref_next[u] = ref_reg[u];
    end
    for (int k = 0; k < 6; k++) val_next[k] = val_reg[k];

    // Address decode
    vhit = (addr_i >= DCU_OFF_VA_BASE) &&
           (addr_i[2:0] <= DCU_VU_VAL2);
    vu   = (addr_i >= DCU_OFF_VB_BASE);
    voff = addr_i[2:0];
    phit = (addr_i >= DCU_OFF_PROBE_FN) &&
           (addr_i < DCU_OFF_PROBE_VAL + 5'h04);
    // Change guard per interface
    if (!sel_reg) begin
      busy = (st_reg[0] == DCU_S_ARMED) ||
             (st_reg[1] == DCU_S_ARMED);
    end else begin
      busy = (pfn[DCU_PB_EN_A] & pst[DCU_PB_EN_A]) |
             (pfn[DCU_PB_EN_B] & pst[DCU_PB_EN_B]);
    end

    // Capture engines: same units whatever the interface
    for (int u = 0; u < 2; u++) begin
      trig = cfg_reg[u][DCU_CFG_SW_BIT] ? swt_reg[u]
           : din_i[cfg_reg[u][DCU_CFG_TRIG_LSB +: 3]];
      trg_next[u] = trig;
      edge_ok = cfg_reg[u][DCU_CFG_BOTH_BIT] ? (trig != trg_reg[u])
              : cfg_reg[u][DCU_CFG_FALL_BIT] ? (trg_reg[u] & ~trig)
              : (~trg_reg[u] & trig);
      case (st_reg[u])
        DCU_S_IDLE: begin
          pend_next[u] = 1'b0;
          if (cmd_reg[u]) st_next[u] = DCU_S_ARMED;
        end
        DCU_S_ARMED: begin
          if (!cmd_reg[u]) begin
            st_next[u] = DCU_S_IDLE;
          end else if (edge_ok && !pend_reg[u]) begin
            // Latch three quantities on the edge
            for (int k = 0; k < 3; k++) val_next[u*3+k] = qty[u*3+k];
            ref_next[u] = qty[u*3];
            if (cfg_reg[u][DCU_CFG_FILT_BIT] && !sel_reg) begin
              pend_next[u] = 1'b1;
            end else begin
              st_next[u] = DCU_S_DONE;
              ist_next[u] = 1'b1;
            end
          end else if (pend_reg[u]) begin
            // Trigger must stay active over the distance
            if (trig == trg_reg[u] &&
                dcu_dist(qty[u*3], ref_reg[u]) >= filt_span_i) begin
              pend_next[u] = 1'b0;
              st_next[u] = DCU_S_DONE;
              ist_next[u] = 1'b1;
            end else if (trig != trg_reg[u]) begin
              pend_next[u] = 1'b0;
            end
          end
        end
        DCU_S_DONE: begin
          if (!cmd_reg[u]) st_next[u] = DCU_S_IDLE;
          else if (cfg_reg[u][DCU_CFG_REP_BIT]) st_next[u] = DCU_S_ARMED;
        end
        default: st_next[u] = DCU_S_IDLE;
      endcase
    end

    // Register reads
    if (rd_i) begin
      if (addr_i == DCU_OFF_SELECT) rdata_next = {31'h0, sel_reg};
      else if (addr_i == DCU_OFF_FAULT) rdata_next = {30'h0, flt_reg};
      else if (addr_i == DCU_OFF_IRQ_STAT) rdata_next = {28'h0, ist_reg};
      else if (addr_i == DCU_OFF_IRQ_MASK) rdata_next = {28'h0, imk_reg};
      else if (vhit || phit) begin
        if (vhit == sel_reg) begin
          // Wrong side reads zero and warns
          flt_next[DCU_FLT_IFACE] = 1'b1;
          ist_next[2] = 1'b1;
        end else if (vhit) begin
          case (voff)
            DCU_VU_CONFIG: rdata_next = {24'h0, cfg_reg[vu]};
            DCU_VU_CMD:    rdata_next = {30'h0, swt_reg[vu], cmd_reg[vu]};
            DCU_VU_STATE:  rdata_next = {30'h0, dcu_code(st_reg[vu])};
            default:
              if (st_reg[vu] == DCU_S_DONE)
                rdata_next = val_reg[vu*3 + 32'(voff - DCU_VU_VAL0)];
          endcase
        end else if (addr_i == DCU_OFF_PROBE_FN) rdata_next = {16'h0, pfn};
        else if (addr_i == DCU_OFF_PROBE_ST) rdata_next = {16'h0, pst};
        else if (st_reg[addr_i[0]] == DCU_S_DONE)
          rdata_next = val_reg[addr_i[0] ? 3 : 0];
      end
    end

    // Register writes
    if (wr_i) begin
      if (addr_i == DCU_OFF_SELECT) begin
        if (!busy && wdata_i[0] != sel_reg) begin
          sel_next = wdata_i[0];
          cmd_next = 2'b00;
          blk_next = 2'b00;
          for (int u = 0; u < 2; u++) begin
            st_next[u] = DCU_S_IDLE;
            // Reload from store if it fits, else defaults
            nc = !nv_ok_i ? DCU_RST_CFG : wdata_i[0]
               ? dcu_p2c(nv_probe_i[u*8 +: 8], DCU_RST_CFG)
               : nv_cfg_i[u*8 +: 8];
            // No filter on probe side or with both edges
            if (wdata_i[0] || nc[DCU_CFG_BOTH_BIT])
              nc[DCU_CFG_FILT_BIT] = 1'b0;
            cfg_next[u] = nc;
          end
        end
      end else if (addr_i == DCU_OFF_FAULT) begin
        // Master clears flags; device never does
        flt_next = flt_next & ~wdata_i[1:0];
      end else if (addr_i == DCU_OFF_IRQ_STAT) begin
        // Clear by one; a same-cycle event sets only a bit that was clear
        ist_next = (ist_reg & ~wdata_i[3:0]) | (ist_next & ~ist_reg);
      end else if (addr_i == DCU_OFF_IRQ_MASK) begin
        imk_next = wdata_i[3:0];
      end else if ((vhit || phit) && vhit == sel_reg) begin
        abort_next = 1'b1;
        flt_next[DCU_FLT_IFACE] = 1'b1;
        ist_next[2] = 1'b1;
      end else if (vhit && voff == DCU_VU_CONFIG) begin
        if (cmd_reg[vu]) begin
          // Refused while enabled
          flt_next[DCU_FLT_SETUP] = 1'b1;
          ist_next[3] = 1'b1;
          blk_next[vu] = 1'b1;
        end else begin
          nc = wdata_i[7:0];
          if (nc[DCU_CFG_BOTH_BIT]) nc[DCU_CFG_FILT_BIT] = 1'b0;
          cfg_next[vu] = nc;
          blk_next[vu] = 1'b0;
        end
      end else if (vhit && voff == DCU_VU_CMD) begin
        swt_next[vu] = wdata_i[DCU_CMD_SWT_BIT];
        if (!wdata_i[DCU_CMD_EN_BIT]) cmd_next[vu] = 1'b0;
        else if (!blk_reg[vu]) cmd_next[vu] = 1'b1;
      end else if (phit && addr_i == DCU_OFF_PROBE_FN) begin
        for (int u = 0; u < 2; u++) begin
          nc = dcu_p2c(wdata_i[u*8 +: 8], cfg_reg[u]);
          if (cmd_reg[u] && nc != cfg_reg[u]) begin
            flt_next[DCU_FLT_SETUP] = 1'b1;
            ist_next[3] = 1'b1;
            abort_next = 1'b1;
          end else begin
            if (!cmd_reg[u]) cfg_next[u] = nc;
            cmd_next[u] = wdata_i[u*8 + DCU_PB_EN_A];
          end
        end
      end else if (phit && addr_i == DCU_OFF_PROBE_ST) begin
        swt_next = {wdata_i[DCU_PB_B_SHIFT + DCU_CMD_SWT_BIT],
                    wdata_i[DCU_CMD_SWT_BIT]};
      end
    end
    irq_next = |(ist_next & imk_next);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sel_reg <= 1'b0; flt_reg <= DCU_RST_FAULT; ist_reg <= 4'h0;
      imk_reg <= 4'h0; cmd_reg <= 2'b00; swt_reg <= 2'b00;
      blk_reg <= 2'b00; trg_reg <= 2'b00; pend_reg <= 2'b00;
      rdata_o <= DCU_UNMAPPED; abort_o <= 1'b0; irq_o <= 1'b0;
      for (int u = 0; u < 2; u++) begin
        cfg_reg[u] <= DCU_RST_CFG; st_reg[u] <= DCU_S_IDLE;
        ref_reg[u] <= 32'h0000_0000;
      end
      for (int k = 0; k < 6; k++) val_reg[k] <= 32'h0000_0000;
    end else begin
      sel_reg <= sel_next; flt_reg <= flt_next; ist_reg <= ist_next;
      imk_reg <= imk_next; cmd_reg <= cmd_next; swt_reg <= swt_next;
      blk_reg <= blk_next; trg_reg <= trg_next; pend_reg <= pend_next;
      rdata_o <= rdata_next; abort_o <= abort_next; irq_o <= irq_next;
      for (int u = 0; u < 2; u++) begin
        cfg_reg[u] <= cfg_next[u]; st_reg[u] <= st_next[u];
        ref_reg[u] <= ref_next[u];
      end
      for (int k = 0; k < 6; k++) val_reg[k] <= val_next[k];
    end
  end
endmodule : dcu_top
`default_nettype wire

//--- sim/dcu_far_model.sv
// Far-side model: trigger lines and measured quantities
`timescale 1ns/1ps
`default_nettype none
module dcu_far_model (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Requests from the bench
  input  wire logic             go_i,
  input  wire logic [2:0]       line_i,
  input  wire logic             step_i,
  // Trigger lines and quantities
  output logic      [7:0]       din_o,
  output logic      [5:0][31:0] qty_o
);
  logic [2:0]  hold_reg, hold_next; // Cycles left in the pulse
  logic [31:0] pos_reg, pos_next;   // Base of all quantities
  // Next pulse length and base
  always_comb begin
    hold_next = (hold_reg != 3'h0) ? hold_reg - 3'h1 : (go_i ? 3'h4 : 3'h0);
    pos_next  = step_i ? pos_reg + 32'h1000 : pos_reg;
  end
  // Register state
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hold_reg <= 3'h0;
      pos_reg  <= 32'h100;
    end else begin
      hold_reg <= hold_next;
      pos_reg  <= pos_next;
    end
  end
  // Pulse gives one rising and one falling edge
  // Line chosen by the bench, index pulse on input 2
  always_comb begin
    din_o = (hold_reg != 3'h0) ? 8'h01 << line_i : 8'h00;
    for (int i = 0; i < 6; i++) qty_o[i] = pos_reg + 32'(i);
  end
endmodule : dcu_far_model
`default_nettype wire

//--- sim/dcu_top_chk.sv
// Checker of bus answers and interface steering
`timescale 1ns/1ps
`default_nettype none
module dcu_top_chk
  import dcu_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic [4:0]  addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        abort_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ------------------------------------------------
  // Steps: select or warning read back
  // ------------------------------------------------
  sequence s_sel(v);
    rd_i && addr_i == DCU_OFF_SELECT ##1 rdata_o[0] == v;
  endsequence
  sequence s_warn;
    rd_i && addr_i == DCU_OFF_FAULT ##1 rdata_o[DCU_FLT_IFACE];
  endsequence
  logic vu; // Mapped vendor unit register
  assign vu = addr_i[4] && (addr_i[2:0] <= DCU_VU_VAL2);
  property p_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  property p_cause; abort_o |-> $past(wr_i); endproperty
  property p_rdok; rd_i |=> !abort_o; endproperty
  property p_unmap; rd_i && addr_i inside {[5'h0A:5'h0F]} |=> rdata_o == 32'h0;
  endproperty
  property p_pv_rd; s_sel(1'b1) ##0 (rd_i && vu) |=> rdata_o == 32'h0;
  endproperty
  property p_pv_wr; s_sel(1'b1) ##0 (wr_i && vu) |=> abort_o; endproperty
  property p_vp_rd;
    s_sel(1'b0) ##0 (rd_i && addr_i inside {[5'h04:5'h09]}) |=> !(|rdata_o);
  endproperty
  property p_vp_wr;
    s_sel(1'b0) ##0 (wr_i && addr_i inside {[5'h04:5'h05]}) |=> abort_o;
  endproperty
  property p_stick;
    s_warn ##0 (rd_i && addr_i == DCU_OFF_FAULT) |=> rdata_o[DCU_FLT_IFACE];
  endproperty
  a_idle: assert property (p_idle)
    else $error("stray read data");
  a_cause: assert property (p_cause)
    else $error("abort without write");
  a_rdok: assert property (p_rdok)
    else $error("abort after read");
  a_unmap: assert property (p_unmap)
    else $error("hole not zero");
  a_pv_rd: assert property (p_pv_rd)
    else $error("vendor read not zero");
  a_pv_wr: assert property (p_pv_wr)
    else $error("vendor write no abort");
  a_vp_rd: assert property (p_vp_rd)
    else $error("probe read not zero");
  a_vp_wr: assert property (p_vp_wr)
    else $error("probe write no abort");
  a_stick: assert property (p_stick)
    else $error("warning dropped");
endmodule : dcu_top_chk
bind dcu_top dcu_top_chk u_chk (.clock_i, .rst_n_i, .addr_i, .wr_i, .rd_i,
  .rdata_o, .abort_o);
`default_nettype wire

//--- sim/dcu_top_tb.sv
// Self-checking bench for the dual capture block
`timescale 1ns/1ps
`default_nettype none
module dcu_top_tb;
  import dcu_pkg::*;
  logic             clock_i, rst_n_i, wr_i, rd_i, abort_o, irq_o;
  logic             nv_ok_i, go, step;
  logic [4:0]       addr_i;
  logic [31:0]      wdata_i, rdata_o, pos, span;
  logic [15:0]      nv_cfg_i, nv_probe_i;
  logic [7:0]       din;
  logic [5:0][31:0] qty;
  int               err_total, n_tests;
  dcu_top u_dut (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .abort_o, .din_i(din), .qty_a0_i(qty[0]), .qty_a1_i(qty[1]),
    .qty_a2_i(qty[2]), .qty_b0_i(qty[3]), .qty_b1_i(qty[4]),
    .qty_b2_i(qty[5]), .filt_span_i(span), .nv_ok_i, .nv_cfg_i,
    .nv_probe_i, .irq_o);
  dcu_far_model u_far (.clock_i, .rst_n_i, .go_i(go), .line_i(3'h2),
    .step_i(step), .din_o(din), .qty_o(qty)); // Input 2
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One access: a write checks abort, a read checks data
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [31:0] d, e);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk(w ? {31'h0, abort_o} : rdata_o, e);
  endtask : acc
  // Read, then at once a second access
  task automatic pair(input logic [4:0] a1, input logic [31:0] e1,
                      input logic w, input logic [4:0] a2,
                      input logic [31:0] d2, e2);
    @(posedge clock_i);
    addr_i <= a1;
    rd_i <= 1'b1;
    @(posedge clock_i);
    addr_i <= a2;
    wdata_i <= d2;
    rd_i <= !w;
    wr_i <= w;
    @(negedge clock_i);
    chk(rdata_o, e1);
    @(posedge clock_i);
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    @(negedge clock_i);
    chk(w ? {31'h0, abort_o} : rdata_o, e2);
  endtask : pair
  // One-cycle request to the far side
  task automatic kick(input logic g, s);
    @(posedge clock_i);
    go <= g;
    step <= s;
    @(posedge clock_i);
    go <= 1'b0;
    step <= 1'b0;
  endtask : kick
  function automatic logic [4:0] ua(input logic b, input logic [2:0] o);
    return (b ? DCU_OFF_VB_BASE : DCU_OFF_VA_BASE) | {2'h0, o};
  endfunction : ua
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Hang guard
  initial begin
    #500000;
    err_total++;
    stop_test();
  end
  initial begin
    {wr_i, rd_i, go, step, nv_ok_i, rst_n_i} = 6'h00;
    {addr_i, wdata_i, nv_cfg_i, nv_probe_i} = '0;
    {err_total, n_tests, pos} = {32'h0, 32'h0, 32'h100};
    span = 32'h0000_0800;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    acc(0, DCU_OFF_SELECT, 0, 0);
    acc(0, DCU_OFF_FAULT, 0, 0);
    acc(0, 5'h0C, 0, 0);
    $display("reset test done");
    acc(1, DCU_OFF_IRQ_MASK, 32'hF, 0);
    acc(1, ua(0, DCU_VU_CONFIG), 32'h2, 0);
    acc(1, ua(0, DCU_VU_CMD), 32'h1, 0);
    acc(0, ua(0, DCU_VU_STATE), 0, 32'(DCU_ST_ARMED));
    acc(0, ua(0, DCU_VU_VAL0), 0, 0);
    kick(1'b1, 1'b0);
    for (int i = 0; i < 20 && irq_o !== 1'b1; i++) @(negedge clock_i);
    chk({31'h0, irq_o}, 32'h1);
    acc(0, ua(0, DCU_VU_STATE), 0, 32'(DCU_ST_DONE));
    for (int i = 0; i < 3; i++)
      acc(0, ua(0, 3'(DCU_VU_VAL0 + i)), 0, pos + i);
    acc(0, DCU_OFF_IRQ_STAT, 0, 32'h1);
    acc(1, DCU_OFF_IRQ_STAT, 32'h1, 0);
    @(negedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    $display("input capture test done");
    kick(1'b0, 1'b1);
    pos = pos + 32'h1000;
    acc(1, ua(1, DCU_VU_CONFIG), 32'h8, 0);
    acc(1, ua(1, DCU_VU_CMD), 32'h1, 0);
    acc(1, ua(1, DCU_VU_CMD), 32'h3, 0);
    acc(0, ua(1, DCU_VU_STATE), 0, 32'(DCU_ST_DONE));
    for (int i = 0; i < 3; i++)
      acc(0, ua(1, 3'(DCU_VU_VAL0 + i)), 0, pos + 3 + i);
    $display("software capture test done");
    // Filter: no motion, so the edge is never validated
    acc(1, ua(0, DCU_VU_CMD), 32'h0, 0);
    acc(1, ua(0, DCU_VU_CONFIG), 32'h82, 0);
    acc(1, ua(0, DCU_VU_CMD), 32'h1, 0);
    kick(1'b1, 1'b0);
    repeat (8) @(posedge clock_i);
    acc(0, ua(0, DCU_VU_STATE), 0, 32'(DCU_ST_ARMED));
    acc(0, ua(0, DCU_VU_VAL0), 0, 0);
    $display("filter test done");
    acc(1, DCU_OFF_SELECT, 32'h1, 0);
    acc(0, DCU_OFF_SELECT, 0, 0);
    acc(1, ua(0, DCU_VU_CONFIG), 32'h42, 0);
    acc(0, ua(0, DCU_VU_CONFIG), 0, 32'h82);
    acc(0, DCU_OFF_FAULT, 0, 32'h2);
    acc(1, ua(0, DCU_VU_CMD), 32'h0, 0);
    acc(1, ua(0, DCU_VU_CMD), 32'h1, 0);
    acc(0, ua(0, DCU_VU_STATE), 0, 32'(DCU_ST_IDLE));
    acc(1, ua(0, DCU_VU_CONFIG), 32'h92, 0);
    acc(0, ua(0, DCU_VU_CONFIG), 0, 32'h12);
    pair(DCU_OFF_SELECT, 0, 1, DCU_OFF_PROBE_FN, 32'h1, 1);
    pair(DCU_OFF_SELECT, 0, 0, DCU_OFF_PROBE_VAL, 0, 0);
    acc(0, DCU_OFF_FAULT, 0, 32'h3);
    $display("vendor refusal test done");
    @(posedge clock_i);
    nv_ok_i <= 1'b1;
    nv_probe_i <= 16'h0404;
    acc(1, DCU_OFF_FAULT, 32'h3, 0);
    acc(1, DCU_OFF_SELECT, 32'h1, 0);
    acc(0, DCU_OFF_PROBE_FN, 0, 32'h404);
    pair(DCU_OFF_SELECT, 1, 0, ua(0, DCU_VU_STATE), 0, 0);
    pair(DCU_OFF_SELECT, 1, 1, ua(0, DCU_VU_CONFIG), 32'h3, 1);
    pair(DCU_OFF_FAULT, 1, 0, DCU_OFF_FAULT, 0, 1);
    acc(1, DCU_OFF_FAULT, 32'h1, 0);
    acc(0, DCU_OFF_FAULT, 0, 0);
    $display("wrong interface test done");
    kick(1'b0, 1'b1);
    pos = pos + 32'h1000;
    acc(1, DCU_OFF_PROBE_FN, 32'h405, 0);
    acc(1, DCU_OFF_PROBE_ST, 32'h2, 0);
    acc(0, DCU_OFF_PROBE_ST, 0, 32'h1);
    acc(0, DCU_OFF_PROBE_VAL, 0, pos);
    acc(1, DCU_OFF_SELECT, 32'h0, 0);
    acc(0, DCU_OFF_SELECT, 0, 32'h1);
    acc(1, DCU_OFF_PROBE_FN, 32'h407, 1);
    acc(0, DCU_OFF_PROBE_FN, 0, 32'h405);
    acc(0, DCU_OFF_FAULT, 0, 32'h2);
    acc(1, DCU_OFF_PROBE_FN, 32'h404, 0);
    @(posedge clock_i);
    nv_ok_i <= 1'b0;
    acc(1, DCU_OFF_SELECT, 32'h0, 0);
    acc(0, DCU_OFF_SELECT, 0, 0);
    acc(0, ua(0, DCU_VU_CONFIG), 0, 32'(DCU_RST_CFG));
    $display("probe interface test done");
    stop_test();
  end
endmodule : dcu_top_tb
`default_nettype wire
